// ===== logic/sebm_pkg.sv
// package: register map, fields, fifo sizes and helpers of the serial master
package sebm_pkg;

    // ========================================================================
    // register byte offsets
    localparam logic [7:0] ADDR_CTRL  = 8'h00;
    localparam logic [7:0] ADDR_STAT  = 8'h04;
    localparam logic [7:0] ADDR_TXDAT = 8'h08;
    localparam logic [7:0] ADDR_RXDAT = 8'h0C;
    localparam logic [7:0] ADDR_ISTAT = 8'h10;
    localparam logic [7:0] ADDR_IMASK = 8'h14;

    // ========================================================================
    // control and status fields
    localparam int CTRL_ON_BIT   = 0;
    localparam int CTRL_ENH_BIT  = 1;
    localparam int CTRL_WORD_BIT = 2;
    localparam int CTRL_PRE_LSB  = 4;
    localparam int STAT_TXF_BIT  = 0;
    localparam int STAT_RXF_BIT  = 1;
    localparam int STAT_BUSY_BIT = 2;
    localparam int STAT_NULL_BIT = 3;
    localparam int STAT_CNT_LSB  = 8;
    localparam int IRQ_RX_BIT    = 0;
    localparam int IRQ_DONE_BIT  = 1;
    localparam int IRQ_WAKE_BIT  = 2;
    localparam int IRQ_W         = 3;

    localparam logic [5:0]       CTRL_RST  = 6'h00;
    localparam logic [IRQ_W-1:0] IMASK_RST = 3'h0;

    // ========================================================================
    // sizes and timing
    localparam int         DATA_W     = 16;
    localparam int         DEPTH      = 4;
    localparam int         PTR_W      = 2;
    localparam int         CNT_W      = 3;
    localparam logic [2:0] CNT_FULL   = 3'h4;
    localparam logic [1:0] NULL_XFERS = 2'h2;
    localparam logic [4:0] SAFE_DIV   = 5'h04;
    localparam logic [4:0] BITS_WORD  = 5'h10;
    localparam logic [4:0] BITS_BYTE  = 5'h08;

    typedef struct packed {
        logic [2:0] prescale;
        logic       wordMode;
        logic       enhMode;
        logic       portOn;
    } sebm_ctrl_t;

    // one sclk half period in core clocks
    function automatic logic [3:0] sebm_half(input logic [2:0] pre);
        return {1'b0, pre} + 4'h1;
    endfunction

    // total core clocks per sclk period
    function automatic logic [4:0] sebm_div(input logic [2:0] pre);
        return {sebm_half(pre), 1'b0};
    endfunction

endpackage

// ===== logic/sebm_shifter.sv
// shift engine: one byte or word, msb first, sample on rising sclk
`timescale 1ns/1ps
module sebm_shifter import sebm_pkg::*; (
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic              start,
    input  wire logic [DATA_W-1:0] txWord,
    input  wire logic              wordMode,
    input  wire logic [3:0]        halfCnt,
    input  wire logic              misoLvl,
    output logic                   busy,
    output logic                   done,
    output logic [DATA_W-1:0]      rxWord,
    output logic                   sclk,
    output logic                   mosi
);
    typedef enum logic [1:0] {SH_IDLE, SH_LOW, SH_HIGH} sebm_sh_t;

    sebm_sh_t          state_ff, nxt_state;
    logic [3:0]        timer_ff, nxt_timer;
    logic [4:0]        bits_ff, nxt_bits;
    logic [DATA_W-1:0] shTx_ff, nxt_shTx, shRx_ff, nxt_shRx;
    logic [DATA_W-1:0] rx_ff, nxt_rx;
    logic              sclk_ff, nxt_sclk, done_ff, nxt_done;

    always_comb begin
        nxt_state = state_ff;
        nxt_timer = timer_ff;
        nxt_bits  = bits_ff;
        nxt_shTx  = shTx_ff;
        nxt_shRx  = shRx_ff;
        nxt_rx    = rx_ff;
        nxt_sclk  = sclk_ff;
        nxt_done  = 1'b0;
        case (state_ff)
            SH_IDLE: begin
                if (start) begin
                    // bytes are left aligned so the msb always leaves first
                    nxt_shTx  = wordMode ? txWord : {txWord[7:0], 8'h00};
                    nxt_bits  = wordMode ? BITS_WORD : BITS_BYTE;
                    nxt_timer = halfCnt - 4'h1;
                    nxt_state = SH_LOW;
                end
            end
            SH_LOW: begin
                if (timer_ff == 4'h0) begin
                    nxt_sclk  = 1'b1;
                    nxt_shRx  = {shRx_ff[DATA_W-2:0], misoLvl};
                    nxt_timer = halfCnt - 4'h1;
                    nxt_state = SH_HIGH;
                end else begin
                    nxt_timer = timer_ff - 4'h1;
                end
            end
            SH_HIGH: begin
                if (timer_ff == 4'h0) begin
                    nxt_sclk  = 1'b0;
                    nxt_bits  = bits_ff - 5'h01;
                    nxt_timer = halfCnt - 4'h1;
                    if (bits_ff == 5'h01) begin
                        nxt_done  = 1'b1;
                        nxt_rx    = wordMode ? shRx_ff
                                             : {8'h00, shRx_ff[7:0]};
                        nxt_state = SH_IDLE;
                    end else begin
                        nxt_shTx  = {shTx_ff[DATA_W-2:0], 1'b0};
                        nxt_state = SH_LOW;
                    end
                end else begin
                    nxt_timer = timer_ff - 4'h1;
                end
            end
            default: nxt_state = SH_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_ff <= SH_IDLE;
            timer_ff <= 4'h0;
            bits_ff  <= 5'h00;
            shTx_ff  <= 16'h0000;
            shRx_ff  <= 16'h0000;
            rx_ff    <= 16'h0000;
            sclk_ff  <= 1'b0;
            done_ff  <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            timer_ff <= nxt_timer;
            bits_ff  <= nxt_bits;
            shTx_ff  <= nxt_shTx;
            shRx_ff  <= nxt_shRx;
            rx_ff    <= nxt_rx;
            sclk_ff  <= nxt_sclk;
            done_ff  <= nxt_done;
        end
    end

    assign busy   = (state_ff != SH_IDLE);
    assign done   = done_ff;
    assign rxWord = rx_ff;
    assign sclk   = sclk_ff;
    assign mosi   = shTx_ff[DATA_W-1];

endmodule

// ===== logic/sebm_spi_master.sv
// serial master with enhanced fifo mode, wake null transfers, apb registers
`timescale 1ns/1ps
// Summary of operation
// - enhanced mode, port on at wake: two zero bytes or words are shifted out after wake, behind at most one queued word that starts in the wake cycle
// - those null transfers put two zero entries into the receive fifo, each dropped if the fifo is full
// - the null pair is sent even when the transmit fifo was empty
// - enhanced mode, divide above 1:4: full flag drops early, a write to the full fifo in the load wait before its last cycle overwrites the newest word
module sebm_spi_master import sebm_pkg::*; (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        sleepReq,
    input  wire logic        miso,
    output logic             sclk,
    output logic             mosi,
    output logic             irq
);
    typedef enum logic [1:0] {XF_IDLE, XF_LOAD, XF_RUN} sebm_xf_t;

    // ========================================================================
    // apb decode
    logic acc, wrAcc, rdAcc, mapped;
    assign acc    = psel & penable;
    assign wrAcc  = acc & pwrite;
    assign rdAcc  = acc & ~pwrite;
    assign mapped = (paddr == ADDR_CTRL)  || (paddr == ADDR_STAT)  ||
                    (paddr == ADDR_TXDAT) || (paddr == ADDR_RXDAT) ||
                    (paddr == ADDR_ISTAT) || (paddr == ADDR_IMASK);
    assign pready  = 1'b1;
    assign pslverr = acc & ~mapped;

    // ========================================================================
    // state
    sebm_ctrl_t        ctrl_ff, nxt_ctrl;
    logic [IRQ_W-1:0]  ist_ff, nxt_ist, imask_ff, nxt_imask;
    logic [DATA_W-1:0] txMem_ff [DEPTH], rxMem_ff [DEPTH];
    logic [DATA_W-1:0] nxt_txMem [DEPTH], nxt_rxMem [DEPTH];
    logic [PTR_W-1:0]  txWr_ff, txRd_ff, rxWr_ff, rxRd_ff;
    logic [PTR_W-1:0]  nxt_txWr, nxt_txRd, nxt_rxWr, nxt_rxRd;
    logic [CNT_W-1:0]  txCnt_ff, rxCnt_ff, nxt_txCnt, nxt_rxCnt;
    sebm_xf_t          xf_ff, nxt_xf;
    logic [3:0]        ldTmr_ff, nxt_ldTmr;
    logic [1:0]        nullLeft_ff, nxt_nullLeft;
    logic              isNull_ff, nxt_isNull, sleep_ff;
    logic [31:0]       rd_ff, nxt_rd;
    logic [2:0]        misoSync_ff;
    logic              misoLvl_ff, nxt_misoLvl;

    logic              slow, txFullFlag, wake, start, shDone, shBusy;
    logic              pushTx, popTx, pushRx, popRx, overwrite;
    logic [DATA_W-1:0] startWord, shRx, rxIn;
    logic [CNT_W-1:0]  flagCnt;

    assign slow = ctrl_ff.enhMode && (sebm_div(ctrl_ff.prescale) > SAFE_DIV);
    assign wake = sleep_ff & ~sleepReq;
    // the word being loaded is already counted gone, so the flag falls early
    assign flagCnt = (slow && xf_ff == XF_LOAD) ? txCnt_ff - 3'h1
                                                : txCnt_ff;
    assign txFullFlag = (flagCnt == CNT_FULL);

    // ========================================================================
    // transfer sequencing and fifos
    always_comb begin
        nxt_xf       = xf_ff;
        nxt_ldTmr    = ldTmr_ff;
        nxt_nullLeft = nullLeft_ff;
        nxt_isNull   = isNull_ff;
        nxt_txMem    = txMem_ff;
        nxt_rxMem    = rxMem_ff;
        start        = 1'b0;
        startWord    = 16'h0000;
        popTx        = 1'b0;
        pushTx       = 1'b0;
        overwrite    = 1'b0;
        popRx        = 1'b0;
        pushRx       = 1'b0;
        rxIn         = isNull_ff ? 16'h0000 : shRx;
        if (wake && ctrl_ff.enhMode && ctrl_ff.portOn) begin
            nxt_nullLeft = NULL_XFERS;
        end
        case (xf_ff)
            XF_IDLE: begin
                if (ctrl_ff.portOn && !sleepReq) begin
                    if (nullLeft_ff != 2'h0) begin
                        start      = 1'b1;
                        nxt_isNull = 1'b1;
                        nxt_xf     = XF_RUN;
                    end else if (txCnt_ff != 3'h0) begin
                        nxt_isNull = 1'b0;
                        if (slow) begin
                            nxt_ldTmr = sebm_half(ctrl_ff.prescale) - 4'h1;
                            nxt_xf    = XF_LOAD;
                        end else begin
                            start     = 1'b1;
                            startWord = txMem_ff[txRd_ff];
                            popTx     = 1'b1;
                            nxt_xf    = XF_RUN;
                        end
                    end
                end
            end
            XF_LOAD: begin
                // the word leaves the fifo only half an sclk after the flag
                if (ldTmr_ff == 4'h0) begin
                    start     = 1'b1;
                    startWord = txMem_ff[txRd_ff];
                    popTx     = 1'b1;
                    nxt_xf    = XF_RUN;
                end else begin
                    nxt_ldTmr = ldTmr_ff - 4'h1;
                end
            end
            XF_RUN: begin
                if (shDone) begin
                    pushRx = (rxCnt_ff != CNT_FULL);
                    if (isNull_ff) begin
                        nxt_nullLeft = nullLeft_ff - 2'h1;
                    end
                    nxt_xf = XF_IDLE;
                end
            end
            default: nxt_xf = XF_IDLE;
        endcase
        if (wrAcc && paddr == ADDR_TXDAT) begin
            if (txCnt_ff != CNT_FULL) begin
                pushTx = 1'b1;
            end else if (slow && xf_ff == XF_LOAD && !popTx) begin
                overwrite = 1'b1;
            end
        end
        if (pushTx) begin
            nxt_txMem[txWr_ff] = pwdata[DATA_W-1:0];
        end
        if (overwrite) begin
            nxt_txMem[txWr_ff - 2'h1] = pwdata[DATA_W-1:0];
        end
        if (pushRx) begin
            nxt_rxMem[rxWr_ff] = rxIn;
        end
        popRx     = rdAcc && paddr == ADDR_RXDAT && rxCnt_ff != 3'h0;
        nxt_txWr  = txWr_ff + {1'b0, pushTx};
        nxt_txRd  = txRd_ff + {1'b0, popTx};
        nxt_rxWr  = rxWr_ff + {1'b0, pushRx};
        nxt_rxRd  = rxRd_ff + {1'b0, popRx};
        nxt_txCnt = txCnt_ff + {2'b00, pushTx} - {2'b00, popTx};
        nxt_rxCnt = rxCnt_ff + {2'b00, pushRx} - {2'b00, popRx};
    end

    // ========================================================================
    // registers, read data and interrupts
    always_comb begin
        nxt_ctrl  = ctrl_ff;
        nxt_imask = imask_ff;
        nxt_rd    = rd_ff;
        nxt_ist   = ist_ff;
        if (wrAcc && paddr == ADDR_CTRL) begin
            nxt_ctrl.portOn   = pwdata[CTRL_ON_BIT];
            nxt_ctrl.enhMode  = pwdata[CTRL_ENH_BIT];
            nxt_ctrl.wordMode = pwdata[CTRL_WORD_BIT];
            nxt_ctrl.prescale = pwdata[CTRL_PRE_LSB +: 3];
        end
        if (wrAcc && paddr == ADDR_IMASK) begin
            nxt_imask = pwdata[IRQ_W-1:0];
        end
        if (rdAcc && paddr == ADDR_ISTAT) begin
            nxt_ist = '0;
        end
        // set after clear so a same-cycle event is never lost
        if (pushRx) nxt_ist[IRQ_RX_BIT] = 1'b1;
        if (shDone) nxt_ist[IRQ_DONE_BIT] = 1'b1;
        if (wake && ctrl_ff.enhMode && ctrl_ff.portOn) begin
            nxt_ist[IRQ_WAKE_BIT] = 1'b1;
        end
        if (psel && !penable) begin
            nxt_rd = 32'h0000_0000;
            case (paddr)
                ADDR_CTRL: begin
                    nxt_rd[CTRL_ON_BIT]       = ctrl_ff.portOn;
                    nxt_rd[CTRL_ENH_BIT]      = ctrl_ff.enhMode;
                    nxt_rd[CTRL_WORD_BIT]     = ctrl_ff.wordMode;
                    nxt_rd[CTRL_PRE_LSB +: 3] = ctrl_ff.prescale;
                end
                ADDR_STAT: begin
                    nxt_rd[STAT_TXF_BIT]          = txFullFlag;
                    nxt_rd[STAT_RXF_BIT]          = rxCnt_ff != 3'h0;
                    nxt_rd[STAT_BUSY_BIT]         = xf_ff != XF_IDLE;
                    nxt_rd[STAT_NULL_BIT]         = nullLeft_ff != 2'h0;
                    nxt_rd[STAT_CNT_LSB +: CNT_W] = txCnt_ff;
                end
                ADDR_RXDAT: nxt_rd[DATA_W-1:0] = rxMem_ff[rxRd_ff];
                ADDR_ISTAT: nxt_rd[IRQ_W-1:0]  = ist_ff;
                ADDR_IMASK: nxt_rd[IRQ_W-1:0]  = imask_ff;
                default:    nxt_rd = 32'h0000_0000;
            endcase
        end
        // miso is filtered: a change counts once stages two and three agree
        nxt_misoLvl = (misoSync_ff[1] == misoSync_ff[2]) ? misoSync_ff[2]
                                                         : misoLvl_ff;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrl_ff     <= CTRL_RST;
            imask_ff    <= IMASK_RST;
            ist_ff      <= '0;
            rd_ff       <= 32'h0000_0000;
            txMem_ff    <= '{default: 16'h0000};
            rxMem_ff    <= '{default: 16'h0000};
            txWr_ff     <= 2'h0;
            txRd_ff     <= 2'h0;
            rxWr_ff     <= 2'h0;
            rxRd_ff     <= 2'h0;
            txCnt_ff    <= 3'h0;
            rxCnt_ff    <= 3'h0;
            xf_ff       <= XF_IDLE;
            ldTmr_ff    <= 4'h0;
            nullLeft_ff <= 2'h0;
            isNull_ff   <= 1'b0;
            sleep_ff    <= 1'b0;
            misoSync_ff <= 3'h0;
            misoLvl_ff  <= 1'b0;
        end else begin
            ctrl_ff     <= nxt_ctrl;
            imask_ff    <= nxt_imask;
            ist_ff      <= nxt_ist;
            rd_ff       <= nxt_rd;
            txMem_ff    <= nxt_txMem;
            rxMem_ff    <= nxt_rxMem;
            txWr_ff     <= nxt_txWr;
            txRd_ff     <= nxt_txRd;
            rxWr_ff     <= nxt_rxWr;
            rxRd_ff     <= nxt_rxRd;
            txCnt_ff    <= nxt_txCnt;
            rxCnt_ff    <= nxt_rxCnt;
            xf_ff       <= nxt_xf;
            ldTmr_ff    <= nxt_ldTmr;
            nullLeft_ff <= nxt_nullLeft;
            isNull_ff   <= nxt_isNull;
            sleep_ff    <= sleepReq;
            misoSync_ff <= {misoSync_ff[1:0], miso};
            misoLvl_ff  <= nxt_misoLvl;
        end
    end

    assign prdata = rd_ff;
    assign irq    = |(ist_ff & imask_ff);

    sebm_shifter u_shifter (
        .core_clk (core_clk),
        .rst      (rst),
        .start    (start),
        .txWord   (startWord),
        .wordMode (ctrl_ff.wordMode),
        .halfCnt  (sebm_half(ctrl_ff.prescale)),
        .misoLvl  (misoLvl_ff),
        .busy     (shBusy),
        .done     (shDone),
        .rxWord   (shRx),
        .sclk     (sclk),
        .mosi     (mosi)
    );

    // ========================================================================
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    chk_wake_null: assert property (
        wake && ctrl_ff.enhMode && ctrl_ff.portOn |=> nullLeft_ff == 2'h2)
        else $error("null pair not armed on wake");
    chk_null_zero: assert property (
        pushRx && isNull_ff |=> rxMem_ff[$past(rxWr_ff)] == 16'h0000)
        else $error("null transfer stored nonzero data");
    chk_null_sent: assert property (
        start && nullLeft_ff != 2'h0 |-> startWord == 16'h0000 ##1 shBusy)
        else $error("null transfer not started with zero");
    chk_flag_early: assert property (
        slow && xf_ff == XF_LOAD && txCnt_ff == CNT_FULL |-> !txFullFlag)
        else $error("full flag did not fall during load");
    chk_flag_true: assert property (
        !slow |-> txFullFlag == (txCnt_ff == CNT_FULL))
        else $error("full flag disagrees with occupancy");
    chk_no_wake_xfer: assert property (
        wake && !ctrl_ff.enhMode && nullLeft_ff == 2'h0
        |=> nullLeft_ff == 2'h0)
        else $error("wake transfer outside enhanced mode");
    chk_full_drop: assert property (
        wrAcc && paddr == ADDR_TXDAT && txCnt_ff == CNT_FULL && !slow
        |=> txCnt_ff == CNT_FULL - {2'b00, $past(popTx)} && $stable(txWr_ff))
        else $error("write to full fifo was not dropped");

    cov_wake_pair: cover property (
        nullLeft_ff == 2'h2 ##[1:200] nullLeft_ff == 2'h0);
    cov_overwrite: cover property (overwrite);
    cov_rx_full:   cover property (rxCnt_ff == CNT_FULL);

endmodule

// ===== tb/sebm_slave.sv
// serial slave model: mode 0, msb first, answers a fixed reply word
`timescale 1ns/1ps
module sebm_slave (
    input  wire logic        sclk,
    input  wire logic        mosi,
    input  wire logic        wordMode,
    input  wire logic [15:0] reply,
    output logic             miso,
    output int               frameCnt,
    output logic [15:0]      got [16]
);
    int          bitCnt;
    logic [15:0] shIn;

    // ========================================================================
    // framing
    initial begin
        frameCnt = 0;
        bitCnt = 0;
        shIn = 16'h0000;
        miso = 1'b0;
    end

    // no select line: the msb of the next frame is presented while idle
    always @(reply or wordMode) begin
        if (bitCnt == 0) begin
            miso = wordMode ? reply[15] : reply[7];
        end
    end

    always @(posedge sclk) begin
        shIn = {shIn[14:0], mosi};
        bitCnt++;
        if (bitCnt == (wordMode ? 16 : 8)) begin
            got[frameCnt[3:0]] = wordMode ? shIn : {8'h00, shIn[7:0]};
            frameCnt++;
            bitCnt = 0;
        end
    end

    always @(negedge sclk) begin
        miso = reply[(wordMode ? 15 : 7) - bitCnt];
    end
endmodule

// ===== tb/tb_sebm_spi_master.sv
// testbench: apb access, data transfers, fifo flags and wake null pair
`timescale 1ns/1ps
module tb_sebm_spi_master import sebm_pkg::*;;
    logic        core_clk = 1'b0;
    logic        rst      = 1'b1;
    logic        psel     = 1'b0;
    logic        penable  = 1'b0;
    logic        pwrite   = 1'b0;
    logic [7:0]  paddr    = 8'h00;
    logic [31:0] pwdata   = 32'h0000_0000;
    logic        sleepReq = 1'b0;
    logic        slvWord  = 1'b0;
    logic [15:0] slvReply = 16'h0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        sclk;
    logic        mosi;
    logic        miso;
    logic        irq;
    int          frameCnt;
    logic [15:0] got [16];
    logic [31:0] rd;
    logic        err;
    int          base;
    int          cycles     = 0;
    int          n_mismatch = 0;
    int          n_tests    = 0;

    always #2.5 core_clk = ~core_clk;

    sebm_spi_master i_dut (.core_clk(core_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sleepReq(sleepReq), .miso(miso), .sclk(sclk), .mosi(mosi),
        .irq(irq));
    sebm_slave i_slave (.sclk(sclk), .mosi(mosi), .wordMode(slvWord),
        .reply(slvReply), .miso(miso), .frameCnt(frameCnt), .got(got));

    // ========================================================================
    // helpers
    task automatic results();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(rd, exp);
    endtask

    // polls until nothing is queued, shifting or pending
    task automatic waitIdle();
        int lim;
        lim = 0;
        rd = 32'hFFFF_FFFF;
        while ((rd & 32'h0000_070C) != 0 && lim < 400) begin
            apb(1'b0, ADDR_STAT, 32'h0000_0000);
            lim++;
        end
        check({31'h0, lim < 400}, 32'h1);
    endtask

    task automatic sleepPulse();
        @(posedge core_clk);
        sleepReq <= 1'b1;
        repeat (4) @(posedge core_clk);
        sleepReq <= 1'b0;
        @(posedge core_clk);
    endtask

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            results();
        end
    end

    // ========================================================================
    // tests
    initial begin
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        rdChk(ADDR_CTRL, 32'h0);
        rdChk(ADDR_IMASK, 32'h0);
        rdChk(ADDR_STAT, 32'h0);
        check({31'h0, err}, 32'h0);
        check({31'h0, pready}, 32'h1);
        apb(1'b0, 8'h18, 32'h0);
        check({31'h0, err}, 32'h1);
        $display("test reset and decode done");

        // plain mode: the miso filter lags four clocks, so half period is five
        slvReply <= 16'h003C;
        apb(1'b1, ADDR_IMASK, 32'h1);
        apb(1'b1, ADDR_CTRL, 32'h41);
        apb(1'b1, ADDR_TXDAT, 32'hA5);
        waitIdle();
        check({16'h0, got[0]}, 32'hA5);
        rdChk(ADDR_RXDAT, 32'h3C);
        check({31'h0, irq}, 32'h1);
        rdChk(ADDR_ISTAT, 32'h3);
        @(posedge core_clk);
        check({31'h0, irq}, 32'h0);
        slvWord <= 1'b1;
        slvReply <= 16'hC35A;
        apb(1'b1, ADDR_CTRL, 32'h45);
        apb(1'b1, ADDR_TXDAT, 32'h1234);
        waitIdle();
        check({16'h0, got[1]}, 32'h1234);
        rdChk(ADDR_RXDAT, 32'hC35A);
        rdChk(ADDR_ISTAT, 32'h3);
        $display("test byte and word transfer done");

        // fill while off, fifth write refused, then start fast or slow
        slvWord <= 1'b0;
        apb(1'b1, ADDR_IMASK, 32'h0);
        base = 2;
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, ADDR_CTRL, 32'h02 | (i * 32'h20));
            for (int k = 1; k <= 5; k++) apb(1'b1, ADDR_TXDAT, k * 32'h11);
            rdChk(ADDR_STAT, 32'h401);
            apb(1'b1, ADDR_CTRL, 32'h03 | (i * 32'h20));
            // slow: sampled inside the load wait, word still queued
            apb(1'b0, ADDR_STAT, 32'h0);
            check(rd & 32'h701, (i == 1) ? 32'h400 : 32'h300);
            // half an sclk after the flag is seen low a write is safe
            repeat (3) @(posedge core_clk);
            apb(1'b1, ADDR_TXDAT, 32'h55);
            waitIdle();
            for (int k = 0; k < 5; k++) check({16'h0, got[base + k]},
                32'h11 * (k + 1));
            // the fifth reply found the receive fifo full and was dropped
            for (int k = 0; k < 4; k++) apb(1'b0, ADDR_RXDAT, 32'h0);
            rdChk(ADDR_STAT, 32'h0);
            check({31'h0, irq}, 32'h0);
            base += 5;
        end
        apb(1'b1, ADDR_IMASK, 32'h2);
        @(posedge core_clk);
        check({31'h0, irq}, 32'h1);
        rdChk(ADDR_ISTAT, 32'h3);
        @(posedge core_clk);
        check({31'h0, irq}, 32'h0);
        $display("test fifo flags done");

        // wake with enhanced mode on and an empty transmit fifo
        apb(1'b1, ADDR_CTRL, 32'h03);
        apb(1'b0, ADDR_ISTAT, 32'h0);
        sleepPulse();
        waitIdle();
        check(32'(frameCnt - base), 32'h2);
        check({16'h0, got[base]}, 32'h0);
        check({16'h0, got[base + 1]}, 32'h0);
        rdChk(ADDR_ISTAT, 32'h7);
        rdChk(ADDR_RXDAT, 32'h0);
        rdChk(ADDR_RXDAT, 32'h0);
        rdChk(ADDR_STAT, 32'h0);
        $display("test wake null pair done");

        // plain mode wake, and enhanced mode with the port turned off before sleep
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, ADDR_CTRL, (i == 1) ? 32'h02 : 32'h01);
            base = frameCnt;
            sleepPulse();
            apb(1'b1, ADDR_CTRL, (i == 1) ? 32'h03 : 32'h01);
            repeat (100) @(posedge core_clk);
            check(32'(frameCnt - base), 32'h0);
            rdChk(ADDR_STAT, 32'h0);
        end
        $display("test quiet wake done");
        results();
    end
endmodule
